/* File: verilog/radio_ctrl.sv */
`timescale 1ns/1ps
module radio_ctrl #(
  parameter int OFF_CYC  = radio_spi_pkg::OFF_CYC,
  parameter int HIB_CYC  = radio_spi_pkg::HIB_CYC,
  parameter int DOZE_CYC = radio_spi_pkg::DOZE_CYC,
  parameter int RXTX_CYC = radio_spi_pkg::RXTX_CYC
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire radio_spi_pkg::apb_req_t apb_req,
  output radio_spi_pkg::apb_rsp_t      apb_rsp,
  input  wire logic                   serial_clock_in,
  input  wire logic                   select_n,
  input  wire logic                   mosi,
  output logic                        miso,
  output logic                        miso_oe_n,
  input  wire logic                   wake_request_n,
  input  wire logic                   radio_sequence_enable,
  output logic                        host_clock_output,
  output logic                        host_clock_oe_n,
  output logic                        osc_on,
  output logic                        rx_on,
  output logic                        tx_on
);

  typedef struct packed {
    radio_spi_pkg::pmode_t   mode;
    logic [21:0]             wait_cnt;
    logic [2:0]              sclk_s;
    logic [2:0]              cs_s;
    logic [1:0]              mosi_s;
    logic [2:0]              wake_s;
    logic [2:0]              seq_s;
    logic                    in_frame;
    logic                    hdr_done;
    logic                    is_read;
    logic                    low_byte;
    logic                    cmd_hit;
    logic [5:0]              addr;
    logic [2:0]              bit_cnt;
    logic [7:0]              shift_in;
    logic [7:0]              shift_out;
    logic [7:0]              hi_byte;
    logic [15:0]             res6;
    logic [15:0]             res7;
    logic [13:0]             hclk_cnt;
    logic                    hclk;
    logic [7:0]              us_pre;
    logic [11:0]             us_cnt;
    logic                    timer_en;
    radio_spi_pkg::apb_rsp_t rsp;
    logic                    miso;
    logic                    miso_oe_n;
    logic                    hclk_oe_n;
    logic                    osc;
    logic                    rx;
    logic                    tx;
    logic                    mem_we;
    logic                    mem_re;
    logic [5:0]              mem_addr;
    logic [15:0]             mem_wdata;
  } state_t;

  state_t      st_reg;
  state_t      st_next;
  logic [15:0] mem_rdata;
  logic [15:0] rd_word;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        cs_fall;
  logic        cs_rise;
  logic        wake_fall;
  logic        seq_rise;
  logic        timer_hit;
  logic        doze_clk_ok;

  generate
    if (OFF_CYC < 1 || OFF_CYC >= 2**22 || HIB_CYC < 1 || HIB_CYC >= 2**22 ||
        DOZE_CYC < 1 || DOZE_CYC >= 2**21 || RXTX_CYC < 1 || RXTX_CYC >= 2**22)
    begin : g_bad
      $error("radio_ctrl: wait count out of range");
    end
  endgenerate

  // Serial port is accepted in Idle and during the radio sequence only
  function automatic logic serial_live(input radio_spi_pkg::pmode_t m);
    serial_live = (m == radio_spi_pkg::PM_IDLE) || (m == radio_spi_pkg::PM_RX_START) ||
                  (m == radio_spi_pkg::PM_RX_ON) || (m == radio_spi_pkg::PM_TX_START) ||
                  (m == radio_spi_pkg::PM_TX_ON);
  endfunction

  // Edges are taken from the second and third stages, never the first
  assign sclk_rise   = st_reg.sclk_s[1] & ~st_reg.sclk_s[2];
  assign sclk_fall   = ~st_reg.sclk_s[1] & st_reg.sclk_s[2];
  assign cs_fall     = ~st_reg.cs_s[1] & st_reg.cs_s[2];
  assign cs_rise     = st_reg.cs_s[1] & ~st_reg.cs_s[2];
  assign wake_fall   = ~st_reg.wake_s[1] & st_reg.wake_s[2];
  assign seq_rise    = st_reg.seq_s[1] & ~st_reg.seq_s[2];
  assign timer_hit   = st_reg.timer_en && (st_reg.us_cnt == st_reg.res6[15:4]);
  assign doze_clk_ok = st_reg.res7[radio_spi_pkg::DOZE_CLK_BIT] &&
                       (st_reg.res7[2:0] >= radio_spi_pkg::DOZE_SEL_MAX);

  // Shadowed resources answer from flops so they read their defaults after reset
  assign rd_word = (st_reg.addr == radio_spi_pkg::POWER_RES)  ? st_reg.res6 :
                   (st_reg.addr == radio_spi_pkg::CLKCFG_RES) ? st_reg.res7 : mem_rdata;

  // Storage moves happen on the core clock only; the pin side is sampled
  resource_ram #(
    .AW (radio_spi_pkg::RES_AW),
    .DW (radio_spi_pkg::RES_DW)
  ) u_ram (
    .pclk  (pclk),
    .we    (st_reg.mem_we),
    .re    (st_reg.mem_re),
    .addr  (st_reg.mem_addr),
    .wdata (st_reg.mem_wdata),
    .rdata (mem_rdata)
  );

  // Whole next state of the block
  always_comb
  begin
    logic [7:0]  byte_in;
    logic [15:0] word_in;
    logic        apb_hit;
    byte_in = {st_reg.shift_in[6:0], st_reg.mosi_s[1]};
    word_in = {st_reg.hi_byte, byte_in};
    apb_hit = (apb_req.paddr == radio_spi_pkg::STATUS_OFF) ||
              (apb_req.paddr == radio_spi_pkg::CONTROL_OFF);
    st_next = st_reg;
    st_next.sclk_s = {st_reg.sclk_s[1:0], serial_clock_in};
    st_next.cs_s   = {st_reg.cs_s[1:0], select_n};
    st_next.mosi_s = {st_reg.mosi_s[0], mosi};
    st_next.wake_s = {st_reg.wake_s[1:0], wake_request_n};
    st_next.seq_s  = {st_reg.seq_s[1:0], radio_sequence_enable};
    st_next.mem_we = 1'b0;
    st_next.mem_re = 1'b0;
    st_next.wait_cnt = (st_reg.wait_cnt == 22'h000000) ? 22'h000000 : st_reg.wait_cnt - 22'h1;

    // Serial transaction engine; ignored outside the live modes
    if (!serial_live(st_reg.mode))
    begin
      st_next.in_frame  = 1'b0;
      st_next.shift_out = 8'h00;
    end
    else if (cs_fall)
    begin
      st_next.in_frame  = 1'b1;
      st_next.hdr_done  = 1'b0;
      st_next.bit_cnt   = 3'h0;
      st_next.low_byte  = 1'b0;
      st_next.cmd_hit   = 1'b0;
      st_next.shift_out = 8'h00;
    end
    else if (cs_rise)
    begin
      st_next.in_frame  = 1'b0;
      st_next.shift_out = 8'h00;
    end
    else if (st_reg.in_frame)
    begin
      if (sclk_rise)
      begin
        st_next.shift_in = byte_in;
        st_next.bit_cnt  = st_reg.bit_cnt + 3'h1;
        if (st_reg.bit_cnt == 3'h7)
        begin
          if (!st_reg.hdr_done)
          begin
            st_next.hdr_done = 1'b1;
            st_next.is_read  = byte_in[radio_spi_pkg::HDR_RW_BIT];
            st_next.addr     = byte_in[5:0];
            st_next.mem_re   = 1'b1;
            st_next.mem_addr = byte_in[5:0];
          end
          else if (!st_reg.is_read)
          begin
            // Write bytes pair high then low into one word
            st_next.low_byte = ~st_reg.low_byte;
            if (!st_reg.low_byte)
            begin
              st_next.hi_byte = byte_in;
            end
            else
            begin
              st_next.mem_we    = 1'b1;
              st_next.mem_addr  = st_reg.addr;
              st_next.mem_wdata = word_in;
              st_next.addr      = st_reg.addr + 6'h01;
              if (st_reg.addr == radio_spi_pkg::CLKCFG_RES)
              begin
                st_next.res7 = word_in;
              end
              if (st_reg.addr == radio_spi_pkg::POWER_RES)
              begin
                st_next.res6    = word_in;
                st_next.cmd_hit = (word_in[1:0] == radio_spi_pkg::PWR_DOZE) ||
                                  (word_in[1:0] == radio_spi_pkg::PWR_HIB);
              end
            end
          end
          else
          begin
            // Prefetch the next word once its low byte has gone out
            st_next.low_byte = ~st_reg.low_byte;
            if (st_reg.low_byte)
            begin
              st_next.addr     = st_reg.addr + 6'h01;
              st_next.mem_re   = 1'b1;
              st_next.mem_addr = st_reg.addr + 6'h01;
            end
          end
        end
      end
      if (sclk_fall)
      begin
        // Output bits only move on the falling edge; zero unless reading
        if (st_reg.bit_cnt == 3'h0 && st_reg.hdr_done && st_reg.is_read)
        begin
          st_next.shift_out = st_reg.low_byte ? rd_word[7:0] : rd_word[15:8];
        end
        else
        begin
          st_next.shift_out = {st_reg.shift_out[6:0], 1'b0};
        end
      end
    end

    // Power mode sequencing
    unique case (st_reg.mode)
      radio_spi_pkg::PM_OFF:
      begin
        if (st_reg.wait_cnt == 22'h000000)
        begin
          st_next.mode = radio_spi_pkg::PM_IDLE;
        end
      end
      radio_spi_pkg::PM_IDLE:
      begin
        if (cs_rise && st_reg.in_frame && st_reg.cmd_hit)
        begin
          st_next.res6[1:0] = 2'h0;
          st_next.mode = (st_reg.res6[1:0] == radio_spi_pkg::PWR_DOZE) ?
                         radio_spi_pkg::PM_DOZE : radio_spi_pkg::PM_HIBERNATE;
        end
        else if (seq_rise)
        begin
          st_next.wait_cnt = 22'(RXTX_CYC - 1);
          st_next.mode = st_reg.res6[radio_spi_pkg::RADIO_TX_BIT] ?
                         radio_spi_pkg::PM_TX_START : radio_spi_pkg::PM_RX_START;
        end
      end
      radio_spi_pkg::PM_HIBERNATE:
      begin
        if (wake_fall)
        begin
          st_next.wait_cnt = 22'(HIB_CYC - 1);
          st_next.mode     = radio_spi_pkg::PM_HIB_WAKE;
        end
      end
      radio_spi_pkg::PM_DOZE:
      begin
        if (wake_fall || timer_hit)
        begin
          // One host clock period is two half periods
          st_next.wait_cnt = 22'(DOZE_CYC - 1) +
                             {7'h00, radio_spi_pkg::HALF_TAB[st_reg.res7[2:0]], 1'b0};
          st_next.mode     = radio_spi_pkg::PM_DOZE_WAKE;
        end
      end
      radio_spi_pkg::PM_HIB_WAKE, radio_spi_pkg::PM_DOZE_WAKE:
      begin
        if (st_reg.wait_cnt == 22'h000000)
        begin
          st_next.mode = radio_spi_pkg::PM_IDLE;
        end
      end
      radio_spi_pkg::PM_RX_START, radio_spi_pkg::PM_TX_START:
      begin
        if (!st_reg.seq_s[1])
        begin
          st_next.mode = radio_spi_pkg::PM_IDLE;
        end
        else if (st_reg.wait_cnt == 22'h000000)
        begin
          st_next.mode = (st_reg.mode == radio_spi_pkg::PM_TX_START) ?
                         radio_spi_pkg::PM_TX_ON : radio_spi_pkg::PM_RX_ON;
        end
      end
      radio_spi_pkg::PM_RX_ON, radio_spi_pkg::PM_TX_ON:
      begin
        if (!st_reg.seq_s[1])
        begin
          st_next.mode = radio_spi_pkg::PM_IDLE;
        end
      end
      default:
      begin
        st_next.mode = radio_spi_pkg::PM_IDLE;
      end
    endcase

    // Microsecond timer for the Doze comparator; idle outside Doze
    if (st_reg.mode == radio_spi_pkg::PM_DOZE)
    begin
      st_next.us_pre = (st_reg.us_pre == 8'(radio_spi_pkg::US_CYC - 1)) ? 8'h00 :
                       st_reg.us_pre + 8'h01;
      if (st_reg.us_pre == 8'(radio_spi_pkg::US_CYC - 1))
      begin
        st_next.us_cnt = st_reg.us_cnt + 12'h001;
      end
    end
    else
    begin
      st_next.us_pre = 8'h00;
      st_next.us_cnt = 12'h000;
    end

    // Host clock divider; stops with the oscillator and gates in Doze unless doze_clk_ok
    st_next.osc = (st_next.mode != radio_spi_pkg::PM_OFF) &&
                  (st_next.mode != radio_spi_pkg::PM_HIBERNATE);
    if (st_next.osc && (st_next.mode != radio_spi_pkg::PM_DOZE || doze_clk_ok))
    begin
      if (st_reg.hclk_cnt >= radio_spi_pkg::HALF_TAB[st_reg.res7[2:0]] - 14'h0001)
      begin
        st_next.hclk_cnt = 14'h0000;
        st_next.hclk     = ~st_reg.hclk;
      end
      else
      begin
        st_next.hclk_cnt = st_reg.hclk_cnt + 14'h0001;
      end
    end
    else
    begin
      st_next.hclk_cnt = 14'h0000;
      st_next.hclk     = 1'b0;
    end

    // Pin drivers; MISO driven only inside a frame, nothing driven in Off
    st_next.miso      = st_next.in_frame & st_next.shift_out[7];
    st_next.miso_oe_n = ~st_next.in_frame | (st_next.mode == radio_spi_pkg::PM_OFF);
    st_next.hclk_oe_n = (st_next.mode == radio_spi_pkg::PM_OFF);
    st_next.rx        = (st_next.mode == radio_spi_pkg::PM_RX_ON);
    st_next.tx        = (st_next.mode == radio_spi_pkg::PM_TX_ON);

    // APB slave: ready one cycle into the access phase, write at that edge
    st_next.rsp.pready  = apb_req.psel & apb_req.penable & ~st_reg.rsp.pready;
    st_next.rsp.pslverr = st_next.rsp.pready & ~apb_hit;
    if (st_next.rsp.pready)
    begin
      st_next.rsp.prdata = 32'h00000000;
      if (!apb_req.pwrite && apb_req.paddr == radio_spi_pkg::STATUS_OFF)
      begin
        st_next.rsp.prdata = {10'h000, st_reg.addr, 8'h00, st_reg.osc,
                              st_reg.hdr_done, st_reg.in_frame, st_reg.hclk,
                              st_reg.mode};
      end
      else if (!apb_req.pwrite && apb_req.paddr == radio_spi_pkg::CONTROL_OFF)
      begin
        st_next.rsp.prdata = {31'h00000000, st_reg.timer_en};
      end
    end
    if (apb_req.psel && apb_req.penable && st_reg.rsp.pready && apb_req.pwrite &&
        apb_req.paddr == radio_spi_pkg::CONTROL_OFF)
    begin
      st_next.timer_en = apb_req.pwdata[0];
    end
  end

  // Single state register; reset values are all constants
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg <= '{mode: radio_spi_pkg::PM_OFF, wait_cnt: 22'(OFF_CYC - 1),
                  sclk_s: 3'h0, cs_s: 3'h7, wake_s: 3'h7, seq_s: 3'h0,
                  res6: radio_spi_pkg::POWER_RST, res7: radio_spi_pkg::CLKCFG_RST,
                  timer_en: radio_spi_pkg::CONTROL_RST, miso_oe_n: 1'b1,
                  hclk_oe_n: 1'b1, default: '0};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign apb_rsp           = st_reg.rsp;
  assign miso              = st_reg.miso;
  assign miso_oe_n         = st_reg.miso_oe_n;
  assign host_clock_output = st_reg.hclk;
  assign host_clock_oe_n   = st_reg.hclk_oe_n;
  assign osc_on            = st_reg.osc;
  assign rx_on             = st_reg.rx;
  assign tx_on             = st_reg.tx;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_doze_cmd;
    st_reg.mode == radio_spi_pkg::PM_IDLE && cs_rise && st_reg.in_frame && st_reg.cmd_hit &&
    st_reg.res6[1:0] == radio_spi_pkg::PWR_DOZE;
  endsequence
  sequence s_rx_ready;
    st_reg.mode == radio_spi_pkg::PM_RX_START && st_reg.wait_cnt == 22'h000000 &&
    st_reg.seq_s[1];
  endsequence

  property p_off_tristate;
    st_reg.mode == radio_spi_pkg::PM_OFF |-> miso_oe_n && host_clock_oe_n;
  endproperty
  a_off_tristate: assert property (p_off_tristate) else $error("output driven in Off");
  property p_doze_entry;
    s_doze_cmd |=> st_reg.mode == radio_spi_pkg::PM_DOZE && st_reg.res6[1:0] == 2'h0
      ##1 (doze_clk_ok || !host_clock_output)[*2];
  endproperty
  a_doze_entry: assert property (p_doze_entry) else $error("doze entry wrong");
  property p_sleep_no_serial;
    (st_reg.mode == radio_spi_pkg::PM_DOZE || st_reg.mode == radio_spi_pkg::PM_HIBERNATE)
      |=> !st_reg.in_frame && miso_oe_n;
  endproperty
  a_sleep_no_serial: assert property (p_sleep_no_serial) else $error("serial live asleep");
  property p_doze_clock_gate;
    st_reg.mode == radio_spi_pkg::PM_DOZE && !doze_clk_ok |-> !host_clock_output;
  endproperty
  a_doze_clock_gate: assert property (p_doze_clock_gate) else $error("doze clock ran");
  property p_hib_wake;
    st_reg.mode == radio_spi_pkg::PM_HIBERNATE && wake_fall
      |=> st_reg.mode == radio_spi_pkg::PM_HIB_WAKE && st_reg.wait_cnt == 22'(HIB_CYC - 1);
  endproperty
  a_hib_wake: assert property (p_hib_wake) else $error("hibernate wake wrong");
  property p_rx_up;
    s_rx_ready |=> st_reg.mode == radio_spi_pkg::PM_RX_ON && rx_on;
  endproperty
  a_rx_up: assert property (p_rx_up) else $error("receiver not up");
  property p_seq_low_idle;
    (st_reg.mode == radio_spi_pkg::PM_RX_ON || st_reg.mode == radio_spi_pkg::PM_TX_ON) &&
      !st_reg.seq_s[1] |=> st_reg.mode == radio_spi_pkg::PM_IDLE ##1 !rx_on && !tx_on;
  endproperty
  a_seq_low_idle: assert property (p_seq_low_idle) else $error("sequence low kept radio");
  property p_frame_start;
    serial_live(st_reg.mode) && cs_fall |=> st_reg.in_frame && !st_reg.hdr_done &&
      st_reg.bit_cnt == 3'h0 ##1 !miso_oe_n && !miso;
  endproperty
  a_frame_start: assert property (p_frame_start) else $error("frame start wrong");
  property p_no_duplex;
    st_reg.in_frame && !(st_reg.hdr_done && st_reg.is_read) |=> !miso;
  endproperty
  a_no_duplex: assert property (p_no_duplex) else $error("data out while writing");
  property p_frame_close;
    serial_live(st_reg.mode) && cs_rise |=> !st_reg.in_frame ##1 miso_oe_n;
  endproperty
  a_frame_close: assert property (p_frame_close) else $error("frame not closed");

endmodule // radio_ctrl

/* File: pkg/radio_spi_pkg.sv */
package radio_spi_pkg;

  // Core clock rate and documented transition times (least times, rounded up)
  localparam int CLK_PERIOD_NS = 4;
  localparam int T_OFF_MIN_MS  = 10;
  localparam int T_HIB_MIN_MS  = 7;
  localparam int T_DOZE_US     = 300;
  localparam int T_RXTX_US     = 144;
  localparam int OFF_CYC  = (T_OFF_MIN_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HIB_CYC  = (T_HIB_MIN_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DOZE_CYC = (T_DOZE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RXTX_CYC = (T_RXTX_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int US_CYC   = 1000 / CLK_PERIOD_NS;
  localparam int WAIT_W   = 22;

  // APB register map
  localparam int               APB_AW      = 8;
  localparam logic [7:0]       STATUS_OFF  = 8'h00;
  localparam logic [7:0]       CONTROL_OFF = 8'h04;
  localparam logic             CONTROL_RST = 1'b0;

  // Serial header and resources
  localparam int               HDR_RW_BIT   = 7;
  localparam int               RES_AW       = 6;
  localparam int               RES_DW       = 16;
  localparam logic [5:0]       POWER_RES    = 6'h06;
  localparam logic [5:0]       CLKCFG_RES   = 6'h07;
  localparam logic [15:0]      POWER_RST    = 16'h0000;
  localparam logic [15:0]      CLKCFG_RST   = 16'h0006;
  localparam int               DOZE_CLK_BIT = 9;
  localparam logic [2:0]       DOZE_SEL_MAX = 3'h4;
  localparam logic [1:0]       PWR_DOZE     = 2'h1;
  localparam logic [1:0]       PWR_HIB      = 2'h2;
  localparam int               RADIO_TX_BIT = 2;
  localparam int               DOZE_CMP_LSB = 4;

  // Host clock half periods in core cycles, index is the frequency select
  localparam logic [7:0][13:0] HALF_TAB = {14'h1DC9, 14'h0EE4, 14'h07D0, 14'h007D,
                                           14'h003E, 14'h001F, 14'h0010, 14'h0008};

  typedef enum logic [3:0] {
    PM_OFF       = 4'h0,
    PM_IDLE      = 4'h1,
    PM_HIBERNATE = 4'h2,
    PM_HIB_WAKE  = 4'h3,
    PM_DOZE      = 4'h4,
    PM_DOZE_WAKE = 4'h5,
    PM_RX_START  = 4'h6,
    PM_RX_ON     = 4'h7,
    PM_TX_START  = 4'h8,
    PM_TX_ON     = 4'h9
  } pmode_t;

  typedef struct packed {
    logic                psel;
    logic                penable;
    logic                pwrite;
    logic [APB_AW-1:0]   paddr;
    logic [31:0]         pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
  } apb_rsp_t;

endpackage

/* File: verilog/resource_ram.sv */
`timescale 1ns/1ps
// Resource store; read data comes from a register and holds until the next read
module resource_ram #(
  parameter int AW = 6,
  parameter int DW = 16
) (
  input  wire logic          pclk,
  input  wire logic          we,
  input  wire logic          re,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata
);

  logic [DW-1:0] mem [2**AW];

  generate
    if (AW < 1 || DW < 8)
    begin : g_bad
      $error("resource_ram: width too small");
    end
  endgenerate

  // No reset: contents are kept through reset and change only on host writes
  always_ff @(posedge pclk)
  begin
    if (we)
    begin
      mem[addr] <= wdata;
    end
    if (re)
    begin
      rdata <= mem[addr];
    end
  end

endmodule // resource_ram

/* File: sim/spi_host.sv */
`timescale 1ns/1ps
// Host serial master, phase and polarity zero, 160 ns clock
module spi_host (
  input  wire logic pclk,
  output logic      sclk,
  output logic      csn,
  output logic      mosi,
  input  wire logic miso
);
  initial
  begin
    sclk = 1'b0; // Clock stands still outside frames
    csn  = 1'b1;
    mosi = 1'b0;
  end
  // Header plus one word: three bytes in one burst, two payload bytes
  task automatic frame(input logic [7:0] hdr, input logic [15:0] wd, output logic [15:0] rd);
    logic [23:0] sh;
    sh = {hdr, wd};
    @(posedge pclk);
    csn <= 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      mosi <= sh[i];
      repeat (20) @(posedge pclk);
      sclk <= 1'b1;
      rd = {rd[14:0], miso};
      repeat (20) @(posedge pclk);
      sclk <= 1'b0;
    end
    mosi <= ~mosi; // Line is flipped after the last bit so no stale bit stays on it
    repeat (20) @(posedge pclk);
    csn <= 1'b1;
    repeat (10) @(posedge pclk);
  endtask
endmodule // spi_host

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic                    pclk = 1'b0;
  logic                    presetn = 1'b0;
  radio_spi_pkg::apb_req_t apb_req = '0;
  radio_spi_pkg::apb_rsp_t apb_rsp;
  logic                    wake_request_n = 1'b1;
  logic                    radio_sequence_enable = 1'b0;
  logic sclk, csn, mosi, miso, miso_oe_n, hco, hco_oe_n, osc_on, rx_on, tx_on, serr;
  int                      drives = 0;
  logic [31:0]             rdat;
  logic [15:0]             rw;
  int                      err_count = 0;
  int                      checks_done = 0;
  always #2 pclk = ~pclk;
  // Remember any drive of the data-out line
  always @(posedge pclk) if (miso_oe_n === 1'b0) drives <= drives + 1;
  // Short counts keep the run brief
  radio_ctrl #(.OFF_CYC(40), .HIB_CYC(30), .DOZE_CYC(20), .RXTX_CYC(16)) u_radio_ctrl (
    .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .serial_clock_in(sclk), .select_n(csn), .mosi(mosi), .miso(miso), .miso_oe_n(miso_oe_n),
    .wake_request_n(wake_request_n), .radio_sequence_enable(radio_sequence_enable),
    .host_clock_output(hco), .host_clock_oe_n(hco_oe_n), .osc_on(osc_on),
    .rx_on(rx_on), .tx_on(tx_on));
  spi_host u_spi_host (.pclk(pclk), .sclk(sclk), .csn(csn), .mosi(mosi), .miso(miso));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // APB transfer; only the watchdog ends the wait for pready
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    apb_req <= '{psel:1'b1, penable:1'b0, pwrite:wr, paddr:a, pwdata:d};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do @(posedge pclk); while (apb_rsp.pready !== 1'b1);
    rdat = apb_rsp.prdata;
    serr = apb_rsp.pslverr;
    apb_req <= '0;
  endtask
  task t_power_up;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    chk({hco_oe_n, miso_oe_n, osc_on}, 3'b110);
    repeat (20) @(posedge pclk);
    apb(1'b0, 8'h00, '0);
    chk(rdat[3:0], 4'h0);
    repeat (60) @(posedge pclk);
    apb(1'b0, 8'h00, '0);
    chk({rdat[3:0], osc_on, hco_oe_n}, 6'h06);
    $display("power up test done");
  endtask
  task t_serial;
    u_spi_host.frame(8'hC7, 16'h0000, rw);
    chk(rw, 16'h0006);
    u_spi_host.frame(8'h07, 16'h0204, rw);
    u_spi_host.frame(8'h87, 16'h0000, rw);
    chk(rw, 16'h0204);
    apb(1'b1, 8'h04, 32'h00000001);
    apb(1'b0, 8'h04, '0);
    chk(rdat, 32'h00000001);
    apb(1'b0, 8'h08, '0);
    chk(serr, 1'b1);
    $display("serial test done");
  endtask
  task t_hibernate;
    int d0;
    u_spi_host.frame(8'h06, 16'h0002, rw);
    chk(osc_on, 1'b0);
    d0 = drives;
    u_spi_host.frame(8'h87, 16'h0000, rw);
    chk(drives - d0, 0);
    wake_request_n <= 1'b0;
    repeat (4) @(posedge pclk);
    wake_request_n <= 1'b1;
    apb(1'b0, 8'h00, '0);
    chk(rdat[3:0], 4'h3);
    repeat (40) @(posedge pclk);
    apb(1'b0, 8'h00, '0);
    chk(rdat[3:0], 4'h1);
    u_spi_host.frame(8'h87, 16'h0000, rw);
    chk(rw, 16'h0204);
    $display("hibernate test done");
  endtask
  task t_doze_and_radio;
    logic v;
    // Timer wake after 1 us, comparator enabled earlier; 1 MHz clock may run
    u_spi_host.frame(8'h06, 16'h0011, rw);
    apb(1'b0, 8'h00, '0);
    chk({rdat[3:0], osc_on}, 5'h09);
    @(negedge pclk);
    v = hco;
    repeat (125) @(negedge pclk);
    chk(hco, !v);
    repeat (600) @(posedge pclk);
    apb(1'b0, 8'h00, '0);
    chk(rdat[3:0], 4'h1);
    // Wake request with timer off; a 2 MHz host clock stays off in Doze
    apb(1'b1, 8'h04, 32'h00000000);
    u_spi_host.frame(8'h07, 16'h0203, rw);
    u_spi_host.frame(8'h06, 16'h0001, rw);
    apb(1'b0, 8'h00, '0);
    chk({rdat[4:0], osc_on, hco}, 7'h12);
    wake_request_n <= 1'b0;
    repeat (4) @(posedge pclk);
    wake_request_n <= 1'b1;
    repeat (400) @(posedge pclk);
    apb(1'b0, 8'h00, '0);
    chk(rdat[3:0], 4'h1);
    u_spi_host.frame(8'h06, 16'h0004, rw);
    radio_sequence_enable <= 1'b1;
    repeat (5) @(posedge pclk);
    chk(tx_on, 1'b0);
    repeat (25) @(posedge pclk);
    chk({tx_on, rx_on}, 2'b10);
    radio_sequence_enable <= 1'b0;
    repeat (10) @(posedge pclk);
    chk(tx_on, 1'b0);
    // Receive path with the transmit select cleared
    u_spi_host.frame(8'h06, 16'h0000, rw);
    radio_sequence_enable <= 1'b1;
    repeat (30) @(posedge pclk);
    chk({tx_on, rx_on}, 2'b01);
    radio_sequence_enable <= 1'b0;
    repeat (10) @(posedge pclk);
    chk(rx_on, 1'b0);
    $display("doze and radio test done");
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    t_power_up();
    t_serial();
    t_hibernate();
    t_doze_and_radio();
    final_report();
  end
  // Whole run needs about 12300 cycles
  initial
  begin
    repeat (40000) @(posedge pclk);
    err_count++;
    final_report();
  end
endmodule // tb_top
